// ===== epd_cmd_consts.vh
// constants for the display controller host-command decoder
`ifndef EPD_CMD_CONSTS_VH
`define EPD_CMD_CONSTS_VH

// ****************************************
// command codes
// ****************************************
`define CMD_LOAD_FULL      8'ha0
`define CMD_STOP_LOAD      8'ha1
`define CMD_DISP_FULL      8'ha2
`define CMD_LOAD_PART      8'hb0
`define CMD_DISP_PART      8'hb1
`define CMD_VERSION        8'he0
`define CMD_DISP_SIZE      8'he2
`define CMD_SOFT_RESET     8'hee
`define CMD_GO_NORMAL      8'hf0
`define CMD_GO_SLEEP       8'hf1
`define CMD_GO_STANDBY     8'hf2
`define CMD_SET_DEPTH      8'hf3
`define CMD_ORIENT         8'hf5
`define CMD_POSITIVE       8'hf7
`define CMD_NEGATIVE       8'hf8
`define CMD_FLASH_WR       8'h01
`define CMD_FLASH_RD       8'h02
`define CMD_REG_WR         8'h10

// ****************************************
// arguments, answers, defaults
// ****************************************
`define DEPTH_1BIT         8'h00
`define DEPTH_2BIT         8'h02
`define DISP_SIZE_CODE     8'h22
`define ORIENT_RESET       2'h1
`define PART_COORD_BYTES   4'h8
`define FLASH_ADDR_BYTES   4'h3
`define FULL_BYTES_1BIT    24'h00ea60
`define FULL_BYTES_2BIT    24'h01d4c0
`define ALIGN_MASK         16'h0003

// power modes
`define PMODE_NORMAL       2'h0
`define PMODE_SLEEP        2'h1
`define PMODE_STANDBY      2'h2

`endif

// ===== epd_host_command_decoder.v
// host-command decoder: bytes from the host bus to settings, answers and actions
`timescale 1ns/1ps
`include "epd_cmd_consts.vh"

// Overview of operation
// RL1: host must display after each partial load before loading another partial picture
// RL2: partial load takes eight coordinate bytes, x1 y1 x2 y2, two bytes each
// RL3: host gives coordinates aligned to four-pixel steps
// RL4: load ends when region byte count reached or stop-loading arrives; code sees stop-loading only before a partial load's first data byte
// RL5: drawing and setting commands accepted only in normal mode
// RL6: display-partial behaves exactly like full display
// RL7: version query returns one byte, normal or sleep mode
// RL8: size query returns fixed byte, normal or sleep mode
// RL9: soft reset resets everything like hardware reset, normal or sleep; code keeps part_x1_o to part_y2_o
// RL10: soft reset runs after strobe returns high; others run on acknowledge
// RL11: host waits about twenty microseconds after soft reset
// RL12: return-to-normal accepted only in sleep mode
// RL13: sleep stops primary clock, runs on slow clock
// RL14: standby halts everything including host link; wake-up sequence only exit
// RL15: host sends nothing after standby, waits 600 us before wake-up
// RL16: depth argument selects one or two bits; others reserved
// RL17: depth changes data format only; full screen 60kB or 120kB
// RL18: orientation codes zero to three rotate 0 to 270 degrees; portrait default
// RL19: orientation and polarity affect only later loads
// RL20: positive gradation default; negative swaps black and white
// RL21: flash write takes three address and one data byte; read returns one
// RL22: register write takes address then data, returns nothing
// RL23: stop-loading aborts any load, normal mode only; code aborts only a partial load before its first data byte
// RL24: loaded data goes to sram; shown only on display command
// RL25: commands invalid in current mode are ignored without side effects
module epd_host_command_decoder #(
  parameter [7:0] VERSION_CODE = 8'h5a   // arbitrary value
) (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        host_write_strobe_n_i,
  input  wire [7:0]  host_data_i,
  input  wire        host_read_strobe_n_i,
  input  wire [7:0]  flash_rd_data_i,
  input  wire        wake_up_i,
  output reg         host_ack_n_o,
  output reg  [7:0]  host_rd_data_o,
  output reg         host_rd_valid_o,
  output reg  [1:0]  power_mode_o,
  output reg         primary_clk_en_o,
  output reg         slow_clk_en_o,
  output reg         depth_2bit_o,
  output reg         depth_reserved_o,
  output reg  [1:0]  orient_o,
  output reg         negative_o,
  output reg         load_active_o,
  output reg         sram_wr_o,
  output reg  [7:0]  sram_data_o,
  output reg  [1:0]  load_orient_o,
  output reg         load_negative_o,
  output reg         display_o,
  output reg  [15:0] part_x1_o,
  output reg  [15:0] part_y1_o,
  output reg  [15:0] part_x2_o,
  output reg  [15:0] part_y2_o,
  output reg         part_mode_o,
  output reg         flash_wr_o,
  output reg         flash_rd_o,
  output reg  [23:0] flash_addr_o,
  output reg  [7:0]  flash_wr_data_o,
  output reg         reg_wr_o,
  output reg  [7:0]  reg_addr_o,
  output reg  [7:0]  reg_data_o,
  output reg         soft_reset_o
);

  // ****************************************
  // decoder states, one-hot
  // ****************************************
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ARG   = 6'h02;
  localparam [5:0] S_COORD = 6'h04;
  localparam [5:0] S_DATA  = 6'h08;
  localparam [5:0] S_FLASH = 6'h10;
  localparam [5:0] S_REG   = 6'h20;

  wire       fall;
  wire       rise;
  reg  [5:0] state_r;
  reg  [7:0] cmd_r;
  reg  [3:0] argn_r;
  reg  [23:0] left_r;
  reg        part_pending_r;
  reg        reset_armed_r;
  reg  [63:0] coord_r;
  wire       normal = (power_mode_o == `PMODE_NORMAL);
  wire       awake  = normal | (power_mode_o == `PMODE_SLEEP);
  wire [15:0] w_px;
  wire [15:0] h_px;
  wire [23:0] area_px;
  wire [23:0] part_bytes;

  epd_strobe_sync u_sync (
    .sys_clk_i  (sys_clk_i),
    .nrst_i     (nrst_i),
    .strobe_n_i (host_write_strobe_n_i),
    .fall_o     (fall),
    .rise_o     (rise)
  );

  // region size from latched coordinates; area of 800x600 fits 24 bits
  assign w_px       = part_x2_o - part_x1_o + 16'h0001;
  assign h_px       = part_y2_o - part_y1_o + 16'h0001;
  assign area_px    = w_px[11:0] * h_px[11:0];
  assign part_bytes = depth_2bit_o ? {2'h0, area_px[23:2]} : {3'h0, area_px[23:3]}; // [RL17]

  // ****************************************
  // command engine
  // ****************************************
  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r          <= S_IDLE;
      cmd_r            <= 8'h00;
      argn_r           <= 4'h0;
      left_r           <= 24'h000000;
      part_pending_r   <= 1'b0;
      reset_armed_r    <= 1'b0;
      coord_r          <= 64'h0;
      host_ack_n_o     <= 1'b1;
      host_rd_data_o   <= 8'h00;
      host_rd_valid_o  <= 1'b0;
      power_mode_o     <= `PMODE_NORMAL;
      primary_clk_en_o <= 1'b1;
      slow_clk_en_o    <= 1'b1;
      depth_2bit_o     <= 1'b0;
      depth_reserved_o <= 1'b0;
      orient_o         <= `ORIENT_RESET;
      negative_o       <= 1'b0;
      load_active_o    <= 1'b0;
      sram_wr_o        <= 1'b0;
      sram_data_o      <= 8'h00;
      load_orient_o    <= `ORIENT_RESET;
      load_negative_o  <= 1'b0;
      display_o        <= 1'b0;
      part_x1_o        <= 16'h0000;
      part_y1_o        <= 16'h0000;
      part_x2_o        <= 16'h0000;
      part_y2_o        <= 16'h0000;
      part_mode_o      <= 1'b0;
      flash_wr_o       <= 1'b0;
      flash_rd_o       <= 1'b0;
      flash_addr_o     <= 24'h000000;
      flash_wr_data_o  <= 8'h00;
      reg_wr_o         <= 1'b0;
      reg_addr_o       <= 8'h00;
      reg_data_o       <= 8'h00;
      soft_reset_o     <= 1'b0;
    end else begin
      sram_wr_o    <= 1'b0;
      display_o    <= 1'b0;
      flash_wr_o   <= 1'b0;
      flash_rd_o   <= 1'b0;
      reg_wr_o     <= 1'b0;
      soft_reset_o <= 1'b0;
      if (!host_read_strobe_n_i)
        host_rd_valid_o <= 1'b0;
      if (flash_rd_o) begin
        host_rd_data_o  <= flash_rd_data_i; // [RL21]
        host_rd_valid_o <= 1'b1;
      end
      if (power_mode_o == `PMODE_STANDBY) begin
        if (rise)
          host_ack_n_o <= 1'b1; // finish the standby write, else ack stays low past wake-up
        if (wake_up_i) begin // [RL14]
          power_mode_o     <= `PMODE_NORMAL;
          primary_clk_en_o <= 1'b1;
          slow_clk_en_o    <= 1'b1;
        end
      end else if (rise) begin
        host_ack_n_o <= 1'b1;
        if (reset_armed_r) begin
          // fire only after strobe is back high so the ack completes
          reset_armed_r <= 1'b0;
          soft_reset_o  <= 1'b1; // [RL10] [RL9]
        end
      end else if (fall) begin
        host_ack_n_o <= 1'b0;
        case (state_r)
          S_IDLE: begin
            cmd_r  <= host_data_i;
            argn_r <= 4'h0;
            case (host_data_i)
              `CMD_LOAD_FULL: if (normal) begin // [RL5]
                state_r         <= S_DATA;
                left_r          <= depth_2bit_o ? `FULL_BYTES_2BIT : `FULL_BYTES_1BIT; // [RL17]
                load_active_o   <= 1'b1;
                part_mode_o     <= 1'b0;
                load_orient_o   <= orient_o; // [RL19]
                load_negative_o <= negative_o;
              end
              `CMD_LOAD_PART: if (normal && !part_pending_r) begin // [RL5] [RL1]
                state_r <= S_COORD;
              end
              `CMD_DISP_FULL, `CMD_DISP_PART: if (normal) begin
                display_o      <= 1'b1; // [RL6] [RL24]
                part_pending_r <= 1'b0;
              end
              `CMD_STOP_LOAD: if (normal) load_active_o <= 1'b0; // [RL23]
              `CMD_VERSION: if (awake) begin
                host_rd_data_o  <= VERSION_CODE; // [RL7]
                host_rd_valid_o <= 1'b1;
              end
              `CMD_DISP_SIZE: if (awake) begin
                host_rd_data_o  <= `DISP_SIZE_CODE; // [RL8]
                host_rd_valid_o <= 1'b1;
              end
              `CMD_SOFT_RESET: if (awake) reset_armed_r <= 1'b1; // [RL10]
              `CMD_GO_NORMAL: if (power_mode_o == `PMODE_SLEEP) begin // [RL12]
                power_mode_o     <= `PMODE_NORMAL;
                primary_clk_en_o <= 1'b1;
              end
              `CMD_GO_SLEEP: if (awake) begin
                power_mode_o     <= `PMODE_SLEEP; // [RL13]
                primary_clk_en_o <= 1'b0;
              end
              `CMD_GO_STANDBY: if (awake) begin
                power_mode_o     <= `PMODE_STANDBY; // [RL14]
                primary_clk_en_o <= 1'b0;
                slow_clk_en_o    <= 1'b0;
              end
              `CMD_SET_DEPTH, `CMD_ORIENT: if (normal) state_r <= S_ARG;
              `CMD_POSITIVE: if (normal) negative_o <= 1'b0; // [RL20]
              `CMD_NEGATIVE: if (normal) negative_o <= 1'b1; // [RL20]
              `CMD_FLASH_WR, `CMD_FLASH_RD: if (normal) state_r <= S_FLASH;
              `CMD_REG_WR: if (normal) state_r <= S_REG;
              default: ; // unknown codes: ignored; wrong-mode codes are dropped by their own mode test [RL25]
            endcase
          end
          S_ARG: begin
            state_r <= S_IDLE;
            if (cmd_r == `CMD_SET_DEPTH) begin
              depth_2bit_o     <= (host_data_i == `DEPTH_2BIT); // [RL16]
              depth_reserved_o <= (host_data_i != `DEPTH_2BIT) && (host_data_i != `DEPTH_1BIT);
            end else begin
              orient_o <= host_data_i[1:0]; // [RL18]
            end
          end
          S_COORD: begin
            coord_r <= {coord_r[55:0], host_data_i}; // [RL2]
            argn_r  <= argn_r + 4'h1;
            if (argn_r == `PART_COORD_BYTES - 4'h1) begin
              // start low bits are cleared and end low bits set; host must keep 4-pixel steps
              part_x1_o       <= coord_r[55:40] & ~`ALIGN_MASK; // [RL3]
              part_y1_o       <= coord_r[39:24] & ~`ALIGN_MASK;
              part_x2_o       <= coord_r[23:8] | `ALIGN_MASK;
              part_y2_o       <= {coord_r[7:0], host_data_i} | `ALIGN_MASK;
              state_r         <= S_DATA;
              left_r          <= 24'h000000;
              load_active_o   <= 1'b1;
              part_mode_o     <= 1'b1;
              part_pending_r  <= 1'b1;
              load_orient_o   <= orient_o; // [RL19]
              load_negative_o <= negative_o;
            end
          end
          S_DATA: begin
            if (!load_active_o) begin
              // load was stopped: byte is a new command byte, retry next strobe
              state_r <= S_IDLE;
            end else if (host_data_i == `CMD_STOP_LOAD && left_r == 24'h000000 && part_mode_o) begin
              load_active_o <= 1'b0;
              state_r       <= S_IDLE;
            end else begin
              sram_wr_o   <= 1'b1; // [RL24]
              sram_data_o <= host_data_i;
              // partial counts up: its size is known only once the coordinates are latched
              left_r      <= part_mode_o ? left_r + 24'h000001 : left_r - 24'h000001;
              if (part_mode_o ? (left_r + 24'h000001 == part_bytes) : (left_r == 24'h000001)) begin
                load_active_o <= 1'b0; // [RL4]
                state_r       <= S_IDLE;
              end
            end
          end
          S_FLASH: begin
            argn_r <= argn_r + 4'h1;
            if (argn_r < `FLASH_ADDR_BYTES)
              flash_addr_o <= {flash_addr_o[15:0], host_data_i}; // [RL21]
            if (argn_r == `FLASH_ADDR_BYTES - 4'h1 && cmd_r == `CMD_FLASH_RD) begin
              flash_rd_o <= 1'b1;
              state_r    <= S_IDLE;
            end
            if (argn_r == `FLASH_ADDR_BYTES) begin
              flash_wr_data_o <= host_data_i;
              flash_wr_o      <= 1'b1; // [RL21]
              state_r         <= S_IDLE;
            end
          end
          S_REG: begin
            argn_r <= argn_r + 4'h1;
            if (argn_r == 4'h0) begin
              reg_addr_o <= host_data_i; // [RL22]
            end else begin
              reg_data_o <= host_data_i;
              reg_wr_o   <= 1'b1; // [RL22]
              state_r    <= S_IDLE;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
      if (soft_reset_o) begin
        // hardware-reset values, except part_x1_o to part_y2_o, coord_r and cmd_r, which keep theirs [RL9]
        state_r          <= S_IDLE;
        part_pending_r   <= 1'b0;
        power_mode_o     <= `PMODE_NORMAL;
        primary_clk_en_o <= 1'b1;
        depth_2bit_o     <= 1'b0;
        depth_reserved_o <= 1'b0;
        orient_o         <= `ORIENT_RESET;
        negative_o       <= 1'b0;
        load_active_o    <= 1'b0;
        host_rd_valid_o  <= 1'b0;
        host_rd_data_o   <= 8'h00;
        slow_clk_en_o    <= 1'b1;
        argn_r           <= 4'h0;
        left_r           <= 24'h000000;
        load_orient_o    <= `ORIENT_RESET;
        load_negative_o  <= 1'b0;
        part_mode_o      <= 1'b0;
        sram_data_o      <= 8'h00;
        flash_addr_o     <= 24'h000000;
        flash_wr_data_o  <= 8'h00;
        reg_addr_o       <= 8'h00;
        reg_data_o       <= 8'h00;
      end
    end
  end

endmodule // epd_host_command_decoder

// ===== epd_host_command_decoder_checker.sv
// assertions on the decoder's ports
`timescale 1ns/1ps
module epd_cmd_checker (
  input logic       sys_clk_i,
  input logic       nrst_i,
  input logic       host_write_strobe_n_i,
  input logic       host_ack_n_o,
  input logic [1:0] power_mode_o,
  input logic       primary_clk_en_o,
  input logic       slow_clk_en_o,
  input logic [1:0] orient_o,
  input logic       negative_o,
  input logic       display_o,
  input logic       flash_wr_o,
  input logic       flash_rd_o,
  input logic       reg_wr_o,
  input logic       sram_wr_o,
  input logic       soft_reset_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_ack_on_fall: assert property ($fell(host_write_strobe_n_i) && power_mode_o != 2'h2
    |-> ##[1:3] !host_ack_n_o) else $error("ack missing after strobe fall");
  chk_ack_on_rise: assert property ($rose(host_write_strobe_n_i) && power_mode_o != 2'h2
    |-> ##[1:3] host_ack_n_o) else $error("ack not released");
  chk_standby_mute: assert property ($fell(host_ack_n_o) |-> $past(power_mode_o) != 2'h2)
    else $error("ack given in standby");
  chk_sleep_clocks: assert property (power_mode_o == 2'h1
    |-> ##[0:1] (!primary_clk_en_o && slow_clk_en_o)) else $error("sleep clock enables wrong");
  chk_standby_clocks: assert property (power_mode_o == 2'h2
    |-> ##[0:1] (!primary_clk_en_o && !slow_clk_en_o)) else $error("standby clocks still on");
  chk_reset_late: assert property (soft_reset_o |-> host_write_strobe_n_i
    && $past(host_write_strobe_n_i) ##1 !soft_reset_o) else $error("soft reset timing wrong");
  chk_reset_effect: assert property (soft_reset_o |-> ##[1:2]
    (orient_o == 2'h1 && !negative_o && power_mode_o == 2'h0)) else $error("soft reset left state");
  chk_exec_on_ack: assert property ((display_o || flash_wr_o || reg_wr_o) |-> !host_ack_n_o)
    else $error("action without ack");
  chk_normal_only: assert property ((display_o || flash_wr_o || flash_rd_o || reg_wr_o
    || sram_wr_o) |-> power_mode_o == 2'h0) else $error("action outside normal mode");
endmodule // epd_cmd_checker
bind epd_host_command_decoder epd_cmd_checker chk_i (.sys_clk_i, .nrst_i, .host_write_strobe_n_i,
  .host_ack_n_o, .power_mode_o, .primary_clk_en_o, .slow_clk_en_o, .orient_o, .negative_o,
  .display_o, .flash_wr_o, .flash_rd_o, .reg_wr_o, .sram_wr_o, .soft_reset_o);

// ===== epd_host_model.sv
// host processor model for the byte-wide strobe and acknowledge bus
`timescale 1ns/1ps
module epd_host_model (
  input  wire       sys_clk_i,
  input  wire       ack_n_i,
  output reg        strb_n_o,
  output reg  [7:0] data_o,
  output reg        rd_n_o
);
  // ****************************************
  // bus tasks
  // ****************************************
  initial begin
    strb_n_o = 1'b1;
    data_o   = 8'h00;
    rd_n_o   = 1'b1;
  end
  // one byte per handshake, hold until acknowledged
  task send(input [7:0] b);
    integer k;
    begin
      @(posedge sys_clk_i);
      strb_n_o <= 1'b0;
      data_o   <= b;
      for (k = 0; k < 20 && ack_n_i !== 1'b0; k++) @(posedge sys_clk_i);
      @(posedge sys_clk_i);
      strb_n_o <= 1'b1;
      // released bus shows no stale byte
      data_o   <= ~b;
      for (k = 0; k < 20 && ack_n_i !== 1'b1; k++) @(posedge sys_clk_i);
      // high time before next strobe
      repeat (3) @(posedge sys_clk_i);
    end
  endtask
  task rd;
    begin
      @(posedge sys_clk_i);
      rd_n_o <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      rd_n_o <= 1'b1;
    end
  endtask
endmodule // epd_host_model

// ===== epd_strobe_sync.v
// write-strobe edge detector for the host bus
`timescale 1ns/1ps
module epd_strobe_sync (
  input  wire sys_clk_i,
  input  wire nrst_i,
  input  wire strobe_n_i,
  output reg  fall_o,
  output reg  rise_o
);
  reg last_r;

  always @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last_r <= 1'b1;
      fall_o <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      last_r <= strobe_n_i;
      fall_o <= last_r & ~strobe_n_i;
      rise_o <= ~last_r & strobe_n_i;
    end
  end
endmodule // epd_strobe_sync

// ===== tb_epd_host_command_decoder.sv
// self-checking bench for the host-command decoder
`timescale 1ns/1ps
`include "epd_cmd_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_epd_host_command_decoder;
  reg         sys_clk_i, nrst_i, wake_up_i;
  reg  [7:0]  flash_rd_data_i;
  wire        strb_n, rd_n, ack_n, rd_valid, d2, dres, neg, lact, sw, lneg, disp, fw, fr, rw, pm;
  wire [1:0]  mode, orient, lor;
  wire [7:0]  rdd, fwd, ra, rdat, hd, sd;
  wire [15:0] x1, y1, x2, y2;
  wire [23:0] fa;
  integer     n_errors = 0, n_compared = 0, cyc = 0, i;
  integer     n_disp = 0, n_sram = 0, n_fwr = 0, n_frd = 0, n_rwr = 0;
  epd_host_model epd_host_model_i (.sys_clk_i(sys_clk_i), .ack_n_i(ack_n), .strb_n_o(strb_n),
    .data_o(hd), .rd_n_o(rd_n));
  epd_host_command_decoder epd_host_command_decoder_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .host_write_strobe_n_i(strb_n), .host_data_i(hd), .host_read_strobe_n_i(rd_n),
    .flash_rd_data_i(flash_rd_data_i), .wake_up_i(wake_up_i), .host_ack_n_o(ack_n),
    .host_rd_data_o(rdd), .host_rd_valid_o(rd_valid), .power_mode_o(mode), .primary_clk_en_o(),
    .slow_clk_en_o(), .depth_2bit_o(d2), .depth_reserved_o(dres), .orient_o(orient),
    .negative_o(neg), .load_active_o(lact), .sram_wr_o(sw), .sram_data_o(sd), .load_orient_o(lor),
    .load_negative_o(lneg), .display_o(disp), .part_x1_o(x1), .part_y1_o(y1), .part_x2_o(x2),
    .part_y2_o(y2), .part_mode_o(pm), .flash_wr_o(fw), .flash_rd_o(fr), .flash_addr_o(fa),
    .flash_wr_data_o(fwd), .reg_wr_o(rw), .reg_addr_o(ra), .reg_data_o(rdat), .soft_reset_o());
  // ****************************************
  // clock, pulse counters, timeout
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // one-cycle pulses are counted, so tasks need not catch the exact edge
  always @(posedge sys_clk_i) begin
    // unknown before the first reset edge must not poison the counts
    n_disp += (disp === 1'b1);
    n_sram += (sw === 1'b1);
    n_fwr  += (fw === 1'b1);
    n_frd  += (fr === 1'b1);
    n_rwr  += (rw === 1'b1);
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict;
    end
  end
  task give_verdict;
    begin
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task s(input [7:0] b);
    epd_host_model_i.send(b);
  endtask
  // aligned region 4,0 to 11,3, big-endian words; x and y differ so a swap shows
  task coords;
    for (i = 0; i < 8; i++) s(i == 1 ? 8'h04 : i == 5 ? 8'h0b : i == 7 ? 8'h03 : 8'h00);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_settings;
    begin
      `CHK("orient", 2'h1, orient)
      `CHK("neg", 1'b0, neg)
      s(`CMD_SET_DEPTH); s(`DEPTH_2BIT); `CHK("d2", 1'b1, d2)
      s(`CMD_SET_DEPTH); s(8'h01); `CHK("dres", 1'b1, dres)
      s(`CMD_SET_DEPTH); s(`DEPTH_1BIT); `CHK("d2", 1'b0, d2)
      for (int k = 0; k < 4; k++) begin
        s(`CMD_ORIENT); s(k[7:0]); `CHK("orient", k[1:0], orient)
      end
      s(`CMD_NEGATIVE); `CHK("neg", 1'b1, neg)
      s(`CMD_POSITIVE); `CHK("neg", 1'b0, neg)
    end
  endtask
  task t_queries;
    begin
      s(`CMD_VERSION); `CHK("valid", 1'b1, rd_valid)
      `CHK("version", 8'h5a, rdd)
      epd_host_model_i.rd; `CHK("valid", 1'b0, rd_valid)
      s(`CMD_DISP_SIZE); `CHK("size", `DISP_SIZE_CODE, rdd)
      epd_host_model_i.rd;
    end
  endtask
  task t_flash_reg;
    begin
      s(`CMD_FLASH_WR); s(8'h12); s(8'h34); s(8'h56); s(8'h9a);
      `CHK("fwr", 1, n_fwr)
      `CHK("faddr", 24'h123456, fa)
      `CHK("fdata", 8'h9a, fwd)
      s(`CMD_FLASH_RD); s(8'h65); s(8'h43); s(8'h21);
      `CHK("frd", 1, n_frd)
      `CHK("faddr", 24'h654321, fa)
      `CHK("fanswer", 8'h3c, rdd)
      epd_host_model_i.rd;
      s(`CMD_REG_WR); s(8'h11); s(8'h80);
      `CHK("rwr", 1, n_rwr)
      `CHK("raddr", 8'h11, ra)
      `CHK("rdata", 8'h80, rdat)
      `CHK("valid", 1'b0, rd_valid)
    end
  endtask
  task t_partial;
    begin
      s(`CMD_ORIENT); s(8'h03); s(`CMD_NEGATIVE);
      s(`CMD_LOAD_PART); coords;
      `CHK("lact", 1'b1, lact)
      `CHK("pmode", 1'b1, pm)
      `CHK("x1", 16'h0004, x1)
      `CHK("y1", 16'h0000, y1)
      `CHK("x2", 16'h000b, x2)
      `CHK("y2", 16'h0003, y2)
      s(8'h81); s(8'h7e); s(8'h5c);
      `CHK("lact", 1'b1, lact)
      s(8'ha3);
      `CHK("sram", 4, n_sram)
      `CHK("sdata", 8'ha3, sd)
      `CHK("lact", 1'b0, lact)
      `CHK("lor", 2'h3, lor)
      `CHK("lneg", 1'b1, lneg)
      `CHK("disp", 0, n_disp)
      s(`CMD_DISP_PART); `CHK("disp", 1, n_disp)
      s(`CMD_LOAD_PART); coords; `CHK("lact", 1'b1, lact)
      s(`CMD_STOP_LOAD); `CHK("lact", 1'b0, lact)
      s(`CMD_DISP_PART); `CHK("disp", 2, n_disp)
    end
  endtask
  task t_power;
    begin
      s(`CMD_GO_SLEEP); `CHK("mode", `PMODE_SLEEP, mode)
      s(`CMD_POSITIVE); `CHK("neg", 1'b1, neg)
      s(`CMD_DISP_FULL); `CHK("disp", 2, n_disp)
      s(`CMD_VERSION); `CHK("valid", 1'b1, rd_valid)
      epd_host_model_i.rd;
      s(`CMD_GO_NORMAL); `CHK("mode", `PMODE_NORMAL, mode)
      s(`CMD_SOFT_RESET);
      repeat (2000) @(posedge sys_clk_i);
      `CHK("neg", 1'b0, neg)
      `CHK("orient", `ORIENT_RESET, orient)
      `CHK("lor", `ORIENT_RESET, lor)
      s(`CMD_GO_STANDBY); `CHK("mode", `PMODE_STANDBY, mode)
      `CHK("ack", 1'b1, ack_n)
      repeat (60000) @(posedge sys_clk_i);
      wake_up_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      wake_up_i <= 1'b0;
      for (i = 0; i < 50 && mode !== `PMODE_NORMAL; i++) @(posedge sys_clk_i);
      `CHK("mode", `PMODE_NORMAL, mode)
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst_i = 1'b0;
    wake_up_i = 1'b0;
    flash_rd_data_i = 8'h3c;
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    t_settings;
    t_queries;
    t_flash_reg;
    t_partial;
    t_power;
    give_verdict;
  end
endmodule // tb_epd_host_command_decoder
